// ===== rtl/acr_top.sv
// Serial-loaded 12-bit setup register of an eight-channel converter.
// Assumes SCLK, CS_N, DIN asynchronous to MCLK and far slower than it;
// RESULT comes from the converter core on MCLK and holds at CS_N fall.
//
// Functional notes
// - Twelve-bit setup register, writable over the link, never readable back.
// - Each setup bit sampled from DIN on an SCLK falling edge.
// - Setup shifts in while previous result shifts out; applies next conversion.
// - Only bits of the first twelve falling edges count; rest ignored.
// - Order MSB first: gate, sequencer, ignored, address, power, mask, ignored, range, coding.
// - Gate bit 1 loads the following eleven bits outside mask frames, power code 00 keeping old power bits; 0 leaves register unchanged.
// - Address takes effect at conversion end: next channel or sequence end.
// - Low two bits of the result channel address go out on DOUT before the result bits.
// - Input multiplexer switches channel on the fourteenth SCLK falling edge.
// - Range bit 0 doubled-reference span, 1 single-reference span, next conversion.
// - Coding bit 0 twos complement, 1 straight binary, next conversion.
// - Sequencer and mask-select bits choose sequencer mode and mask-register target.
// - Two power mode bits decode the converter power mode.
// - Power code 11 keeps the converter fully powered always.
// - Sequencer bits 00: each conversion uses address of prior write.
// - Output word: two zeros, two address bits, twelve result bits MSB first.
`timescale 1ns/1ps
`default_nettype none
`include "acr_defines.svh"

module acr_top (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Serial link pins
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic DIN,
  output logic DOUT,
  output logic DOUT_OE,
  // Converter core side
  input wire logic [`ACR_RES_W-1:0] RESULT,
  output logic [`ACR_CH_W-1:0] MUX_CHANNEL,
  output logic RANGE_SINGLE,
  output logic CODING_BINARY,
  output logic [1:0] POWER_MODE,
  output logic FULL_POWER,
  output logic [1:0] SEQ_MODE,
  output logic SEQ_ACTIVE,
  output logic MASK_TARGET
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  acr_sync_if #(.W(3)) pins ();

  // Idle levels of {CS_N, SCLK, DIN}
  acr_sync #(.W(3), .INIT(3'h6)) u_sync (
    .clk(MCLK),
    .rst(SYS_RST),
    .raw({CS_N, SCLK, DIN}),
    .sync(pins.src)
  );

  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic din_s;

  assign cs_fall = pins.fall[2];
  assign cs_rise = pins.rise[2];
  assign sclk_fall = pins.fall[1];
  assign din_s = pins.lvl[0];

  ////////////////////////////////////////////////////////////////////////
  // State

  acr_pkg::acr_state_e st_r, st_nxt;
  logic [`ACR_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [`ACR_CFG_W-2:0] shin_r, shin_nxt;
  logic [`ACR_WORD_W-1:0] shout_r, shout_nxt;
  logic dout_r, dout_nxt;
  logic doe_r, doe_nxt;
  acr_pkg::acr_cfg_s pend_r, pend_nxt;
  logic pend_v_r, pend_v_nxt;
  acr_pkg::acr_cfg_s cfg_r, cfg_nxt;
  logic [`ACR_CH_W-1:0] mux_r, mux_nxt;
  logic seq_run_r, seq_run_nxt;
  logic mask_sel_r, mask_sel_nxt;
  logic full_pwr_r, full_pwr_nxt;

  acr_pkg::acr_cfg_s eff;
  acr_pkg::acr_cfg_s word;
  logic [1:0] mode;
  logic [1:0] pend_mode;
  logic run_next;
  logic [`ACR_CH_W-1:0] ch_next;

  // Setup in force for the coming conversion
  always_comb begin
    eff = pend_v_r ? pend_r : cfg_r;
    mode = {eff.sequencer_control, eff.mask_select};
    pend_mode = {pend_r.sequencer_control, pend_r.mask_select};
    word = acr_pkg::acr_cfg_s'({shin_r, din_s});
    if (pend_v_r) begin
      run_next = (mode == `ACR_SEQ_CONSEC) || ((mode == `ACR_SEQ_KEEP) && seq_run_r);
    end else begin
      run_next = seq_run_r;
    end
    if (pend_v_r && (mode == `ACR_SEQ_CONSEC)) begin
      ch_next = '0;
    end else if (run_next) begin
      ch_next = (mux_r >= eff.channel_address) ? '0 : mux_r + 3'h1;
    end else begin
      ch_next = eff.channel_address;
    end
  end

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    shin_nxt = shin_r;
    shout_nxt = shout_r;
    dout_nxt = dout_r;
    doe_nxt = doe_r;
    pend_nxt = pend_r;
    pend_v_nxt = pend_v_r;
    cfg_nxt = cfg_r;
    mux_nxt = mux_r;
    seq_run_nxt = seq_run_r;
    mask_sel_nxt = mask_sel_r;
    full_pwr_nxt = full_pwr_r;
    case (st_r)
      acr_pkg::ACR_IDLE: begin
        doe_nxt = 1'b0;
        dout_nxt = 1'b0;
        if (cs_fall) begin
          st_nxt = acr_pkg::ACR_XFER;
          cnt_nxt = '0;
          pend_v_nxt = 1'b0;
          doe_nxt = 1'b1;
          shout_nxt = {`ACR_LEAD_ZEROS, mux_r[1:0], RESULT};
        end
      end
      acr_pkg::ACR_XFER: begin
        if (cs_rise) begin
          st_nxt = acr_pkg::ACR_IDLE;
          doe_nxt = 1'b0;
          dout_nxt = 1'b0;
          mask_sel_nxt = pend_v_r && (pend_mode == `ACR_SEQ_MASK);
          if (pend_v_r) begin
            cfg_nxt = pend_r;
            if ({pend_r.power_mode_high, pend_r.power_mode_low} == `ACR_PM_INVALID) begin
              cfg_nxt.power_mode_high = cfg_r.power_mode_high;
              cfg_nxt.power_mode_low = cfg_r.power_mode_low;
            end
            full_pwr_nxt = ({cfg_nxt.power_mode_high, cfg_nxt.power_mode_low}
                            == `ACR_PM_NORMAL);
          end
        end else if (sclk_fall && (cnt_r != `ACR_WORD_EDGES)) begin
          cnt_nxt = cnt_r + 5'h01;
          dout_nxt = shout_r[`ACR_WORD_W-2];
          shout_nxt = {shout_r[`ACR_WORD_W-2:0], 1'b0};
          if (cnt_r < `ACR_CFG_EDGES - 5'h01) begin
            shin_nxt = {shin_r[`ACR_CFG_W-3:0], din_s};
          end
          if ((cnt_r == `ACR_CFG_EDGES - 5'h01) && !mask_sel_r && word.write_gate) begin
            pend_nxt = word;
            pend_v_nxt = 1'b1;
          end
          if (cnt_r == `ACR_MUX_EDGE - 5'h01) begin
            mux_nxt = ch_next;
            seq_run_nxt = run_next;
          end
        end
      end
      default: begin
        st_nxt = acr_pkg::ACR_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st_r <= acr_pkg::ACR_IDLE;
      cnt_r <= '0;
      shin_r <= '0;
      shout_r <= '0;
      dout_r <= 1'b0;
      doe_r <= 1'b0;
      pend_r <= acr_pkg::acr_cfg_s'(`ACR_CFG_RESET);
      pend_v_r <= 1'b0;
      cfg_r <= acr_pkg::acr_cfg_s'(`ACR_CFG_RESET);
      mux_r <= '0;
      seq_run_r <= 1'b0;
      mask_sel_r <= 1'b0;
      full_pwr_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      shin_r <= shin_nxt;
      shout_r <= shout_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      pend_r <= pend_nxt;
      pend_v_r <= pend_v_nxt;
      cfg_r <= cfg_nxt;
      mux_r <= mux_nxt;
      seq_run_r <= seq_run_nxt;
      mask_sel_r <= mask_sel_nxt;
      full_pwr_r <= full_pwr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign DOUT = dout_r;
  assign DOUT_OE = doe_r;
  assign MUX_CHANNEL = mux_r;
  assign RANGE_SINGLE = cfg_r.range_single;
  assign CODING_BINARY = cfg_r.coding_binary;
  assign POWER_MODE = {cfg_r.power_mode_high, cfg_r.power_mode_low};
  assign FULL_POWER = full_pwr_r;
  assign SEQ_MODE = {cfg_r.sequencer_control, cfg_r.mask_select};
  assign SEQ_ACTIVE = seq_run_r;
  assign MASK_TARGET = mask_sel_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  logic in_xfer;
  assign in_xfer = (st_r == acr_pkg::ACR_XFER);

  cfg_frame_end_a: assert property (
    $changed(cfg_r) |-> $past(cs_rise && in_xfer && pend_v_r))
    else $error("setup register changed outside a frame end");

  din_sample_a: assert property (
    in_xfer && !cs_rise && sclk_fall && (cnt_r < 5'h0b) |=> shin_r[0] == $past(din_s))
    else $error("setup bit not taken from DIN on SCLK fall");

  late_bits_a: assert property (
    in_xfer && !cs_rise && sclk_fall && (cnt_r >= 5'h0c) |=> $stable(shin_r) && $stable(pend_r))
    else $error("input bit after edge twelve was used");

  gate_zero_a: assert property (
    in_xfer && !cs_rise && sclk_fall && (cnt_r == 5'h0b) && !shin_r[10]
    |=> !pend_v_r)
    else $error("write with gate zero was accepted");

  gate_one_a: assert property (
    in_xfer && !cs_rise && sclk_fall && (cnt_r == 5'h0b) && shin_r[10] && !mask_sel_r
    |=> pend_v_r && (pend_r == $past({shin_r, din_s})))
    else $error("gated write not captured in order");

  mux_edge_a: assert property (
    $changed(mux_r) |-> $past(in_xfer && sclk_fall && (cnt_r == 5'h0d)))
    else $error("multiplexer switched off the fourteenth edge");

  direct_chan_a: assert property (
    in_xfer && !cs_rise && sclk_fall && (cnt_r == 5'h0d) && (mode == 2'h0) && !seq_run_r
    |=> mux_r == $past(eff.channel_address))
    else $error("direct mode did not use written address");

  word_head_a: assert property (
    st_r == acr_pkg::ACR_IDLE && cs_fall
    |=> DOUT_OE && !DOUT && (shout_r == {2'h0, $past(mux_r[1:0]), $past(RESULT)}))
    else $error("output word head wrong");

  apply_next_a: assert property (
    in_xfer && cs_rise && pend_v_r
    |=> (RANGE_SINGLE == $past(pend_r.range_single))
        && (CODING_BINARY == $past(pend_r.coding_binary)) && !DOUT_OE)
    else $error("range or coding not applied at frame end");

  full_power_a: assert property (
    FULL_POWER == (POWER_MODE == 2'h3))
    else $error("full power flag disagrees with power mode");

  mask_target_a: assert property (
    in_xfer && cs_rise && pend_v_r && (pend_mode == 2'h1) |=> MASK_TARGET)
    else $error("mask target not armed");

  mask_frame_a: assert property (
    in_xfer && !cs_rise && sclk_fall && (cnt_r == 5'h0b) && mask_sel_r |=> !pend_v_r)
    else $error("setup loaded during a mask frame");

  cfg_write_c: cover property (in_xfer && cs_rise && pend_v_r);
  consec_wrap_c: cover property (SEQ_ACTIVE && $changed(mux_r) && (mux_r == 3'h0));
  mask_frame_c: cover property (MASK_TARGET && $rose(DOUT_OE));

endmodule : acr_top

`default_nettype wire

// ===== rtl/acr_defines.svh
// Constants of the serial-loaded converter setup register block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

`define ACR_CFG_W 12
`define ACR_WORD_W 16
`define ACR_RES_W 12
`define ACR_CH_W 3
`define ACR_CNT_W 5
// Falling-edge counts inside one frame
`define ACR_CFG_EDGES 5'h0c
`define ACR_MUX_EDGE 5'h0e
`define ACR_WORD_EDGES 5'h10
// Setup register default: normal power, no sequencing, channel 0
`define ACR_CFG_RESET 12'h030
// Power mode codes
`define ACR_PM_NORMAL 2'h3
`define ACR_PM_SHUTDOWN 2'h2
`define ACR_PM_AUTO 2'h1
`define ACR_PM_INVALID 2'h0
// Sequencer modes {sequencer_control, mask_select}
`define ACR_SEQ_OFF 2'h0
`define ACR_SEQ_MASK 2'h1
`define ACR_SEQ_KEEP 2'h2
`define ACR_SEQ_CONSEC 2'h3
`define ACR_LEAD_ZEROS 2'h0

`endif

// ===== rtl/acr_pkg.sv
// Types of the converter setup register block.
// Assumes acr_defines.svh is on the include path.
`include "acr_defines.svh"

package acr_pkg;

  typedef enum logic [1:0] {
    ACR_IDLE = 2'b01,
    ACR_XFER = 2'b10
  } acr_state_e;

  // Bit 11 first on the wire
  typedef struct packed {
    logic write_gate;
    logic sequencer_control;
    logic ignored_bit_hi;
    logic [`ACR_CH_W-1:0] channel_address;
    logic power_mode_high;
    logic power_mode_low;
    logic mask_select;
    logic ignored_bit_lo;
    logic range_single;
    logic coding_binary;
  } acr_cfg_s;

endpackage : acr_pkg

// ===== rtl/acr_sync_if.sv
// Carrier for synchronised pin levels and their edges.
// Assumes one producer (acr_sync) and one consumer on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface acr_sync_if #(parameter int W = 1);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface : acr_sync_if

`default_nettype wire

// ===== rtl/acr_sync.sv
// Two-flop synchroniser with edge detection behind the second stage.
// Assumes raw inputs asynchronous to clk; one clk of latency per stage.
`timescale 1ns/1ps
`default_nettype none

module acr_sync #(
  parameter int W = 1,
  // Reset level of every stage; idle pin level avoids a false edge
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous inputs
  input wire logic [W-1:0] raw,
  // Synchronised view
  acr_sync_if.src sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;
  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;

  always_comb begin
    meta_nxt = raw;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= INIT;
      sync_r <= INIT;
      prev_r <= INIT;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // Edges only from the second and third stages
  assign sync.lvl = sync_r;
  assign sync.rise = sync_r & ~prev_r;
  assign sync.fall = ~sync_r & prev_r;

endmodule : acr_sync

`default_nettype wire

// ===== tb/acr_host.sv
// Host serial master model: frames of n clocks, DIN out, DOUT captured.
// Assumes the bench clock as timing base; SCLK period is 20 of its cycles.
`timescale 1ns/1ps
`default_nettype none

module acr_host (
  // Timing base
  input wire logic clk,
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end

  //////////////////////////////
  // One frame of n falling edges, read word MSB first
  task automatic frame(input logic [15:0] w, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    cs_n = 1'b0;
    din = w[15];
    repeat (10) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      rd[15-i] = dout;
      sclk = 1'b0;
      repeat (10) @(negedge clk);
      sclk = 1'b1;
      din = (i < 15) ? w[14-i] : ~din;
      repeat (10) @(negedge clk);
    end
    cs_n = 1'b1;
    // Released data line does not keep its last level
    din = ~din;
    repeat (8) @(negedge clk);
  endtask : frame
endmodule : acr_host

`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the converter setup register block.
// Assumes acr_pkg compiled first and acr_defines.svh on the include path.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic mclk, rst, sclk, cs_n, din, dout, dout_oe;
  logic [11:0] result;
  logic [2:0] mux_channel, ech, ead;
  logic [1:0] power_mode, seq_mode, epm, emode;
  logic range_single, coding_binary, full_power, seq_active, mask_target;
  logic erng, ecod, eact, emt;
  int miscompares = 0;
  int n_compared = 0;
  logic [15:0] tw [10];
  int tn [10] = '{16, 11, 16, 16, 16, 16, 16, 16, 16, 16};
  logic [1:0] tc [10] = '{2'h3, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h2};

  acr_top dut (.MCLK(mclk), .SYS_RST(rst), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
    .DOUT(dout), .DOUT_OE(dout_oe), .RESULT(result), .MUX_CHANNEL(mux_channel),
    .RANGE_SINGLE(range_single), .CODING_BINARY(coding_binary),
    .POWER_MODE(power_mode), .FULL_POWER(full_power), .SEQ_MODE(seq_mode),
    .SEQ_ACTIVE(seq_active), .MASK_TARGET(mask_target));

  acr_host host (.clk(mclk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  //////////////////////////////
  // Word from {gate,seq}, address, power, {mask,range,coding}
  function automatic logic [15:0] cfg(input logic [1:0] gs, input logic [2:0] ch,
      input logic [1:0] pm, input logic [2:0] mrc);
    return {gs, 1'b0, ch, pm, mrc[2], 1'b0, mrc[1:0], 4'hf};
  endfunction : cfg

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic complete_run();
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic state_ok(input logic ckm);
    if (ckm) chk(16'(mux_channel), 16'(ech));
    chk(16'(range_single), 16'(erng));
    chk(16'(coding_binary), 16'(ecod));
    chk(16'(power_mode), 16'(epm));
    chk(16'(full_power), 16'(epm == 2'h3));
    chk(16'(seq_mode), 16'(emode));
    chk(16'(seq_active), 16'(eact));
    chk(16'(mask_target), 16'(emt));
    chk(16'(dout_oe), 16'h0000);
  endtask : state_ok

  task automatic xfer(input logic [15:0] w, input int n, input logic [1:0] ck);
    logic [15:0] rd;
    logic ld;
    result = result + 12'h3a5;
    host.frame(w, n, rd);
    if (ck[0]) chk(rd, {2'b00, ech[1:0], result});
    ld = (n >= 12) && w[15] && !emt;
    if (ld) begin
      ead = w[12:10];
      erng = w[5];
      ecod = w[4];
      epm = w[9:8];
      emode = {w[14], w[7]};
    end
    // Channel and sequencer move only on the fourteenth fall
    if (n >= 14) begin
      if (ld) begin
        eact = (emode == 2'h3) || (emode == 2'h2 && eact);
      end
      if (ld && emode == 2'h3) begin
        ech = 3'h0;
      end else if (eact) begin
        ech = (ech >= ead) ? 3'h0 : ech + 3'h1;
      end else begin
        ech = ead;
      end
    end
    // Mask frame consumes the pending target
    emt = ld && emode == 2'h1;
    state_ok(ck[1]);
  endtask : xfer

  //////////////////////////////
  initial begin
    rst = 1'b1;
    result = 12'h000;
    ech = 3'h0;
    ead = 3'h0;
    erng = 1'b0;
    ecod = 1'b0;
    epm = 2'h3;
    emode = 2'h0;
    eact = 1'b0;
    emt = 1'b0;
    // No entry uses power code 00
    tw = '{cfg(2'h1, 3'h2, 2'h2, 3'h4), cfg(2'h2, 3'h2, 2'h2, 3'h0),
      cfg(2'h2, 3'h6, 2'h2, 3'h2), cfg(2'h2, 3'h7, 2'h3, 3'h1),
      cfg(2'h3, 3'h2, 2'h3, 3'h4), cfg(2'h3, 3'h2, 2'h1, 3'h3),
      cfg(2'h2, 3'h3, 2'h3, 3'h0), cfg(2'h2, 3'h3, 2'h3, 3'h4),
      16'hffff, cfg(2'h2, 3'h4, 2'h3, 3'h1)};
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    state_ok(1'b1);
    fork
      xfer(cfg(2'h2, 3'h5, 2'h1, 3'h3), 16, 2'h3);
      begin
        repeat (265) @(negedge mclk);
        chk(16'(mux_channel), 16'h0000);
        chk(16'(dout_oe), 16'h0001);
        repeat (20) @(negedge mclk);
        chk(16'(mux_channel), 16'h0005);
      end
    join
    // Gate off, short frame, power codes, all sequencer modes, mask frame
    for (int i = 0; i < 10; i++) begin
      xfer(tw[i], tn[i], tc[i]);
    end
    complete_run();
  end
endmodule : tb

`default_nettype wire
